// ---- rtl/pattern_trigger_time_qualifier.sv ----
// pattern trigger with time qualification, holdoff and auto mode
// What this block does
// - pattern element per channel plus aux
// - combining function AND, NAND, OR, NOR
// - all-ignore pattern triggers only by auto force
// - level write decrements channel selector
// - auto mode forces after timebase wait
// - normal mode never forces
// - holdoff is set in percent
// - timer runs while pattern is true
// - timeout fires when limit reached
// - smallest limit is one 25 ns cycle (2 ns rounded up)
// - other qualifiers decide on pattern false
// - longer-than fires if duration exceeded limit
// - limit mode: shorter, longer, timeout
// - range mode: lower and upper limits
// - truth table of the four functions
// - shorter-than fires if ended before limit
// - in-range fires between the limits
// - out-of-range fires outside the limits
`timescale 1ns/1ps
module pattern_trigger_time_qualifier #(
  parameter int unsigned P_HOLDOFF_STEP = trig_pkg::HOLDOFF_STEP_CYC,
  parameter int unsigned P_AUTO_SCALE = trig_pkg::AUTO_SCALE_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // probed inputs, [15:0] channels, [16] aux
  input wire logic [16:0] i_probe,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // trigger out
  output logic o_trig,
  output logic o_forced
);

  typedef enum logic [2:0] {ST_IDLE, ST_HOLDOFF, ST_WAIT_FALSE, ST_ARMED, ST_TIMING} state_t;

  state_t state;
  state_t next_state;
  logic ctrl_en;
  logic ctrl_auto;
  trig_pkg::logic_func_t func;
  trig_pkg::qual_t qual;
  logic [4:0] channel_selector;
  trig_pkg::pattern_t pattern;
  logic [31:0] limit;
  logic [31:0] upper;
  logic [7:0] holdoff_pct;
  logic [15:0] timebase;
  logic [31:0] trig_count;
  logic [31:0] timer;
  logic [31:0] hold_cnt;
  logic [31:0] auto_cnt;
  logic pat_true;
  logic pat_prev;
  logic rise;
  logic fall;
  logic [31:0] eff_limit;
  logic [31:0] eff_upper;
  logic [31:0] dur_now;
  logic [31:0] auto_wait;
  logic armed_phase;
  logic timeout_hit;
  logic gate_hit;
  logic qual_fire;
  logic force_now;
  logic fire;
  logic [31:0] read_val;

  // ------------------------------------------------------------
  // qualifier decision at the moment the pattern goes false
  // ------------------------------------------------------------
  function automatic logic qual_met(input trig_pkg::qual_t q, input logic [31:0] dur,
                                    input logic [31:0] lo, input logic [31:0] hi);
    case (q)
      trig_pkg::Q_SHORTER: qual_met = (dur < lo);
      trig_pkg::Q_LONGER: qual_met = (dur > lo);
      trig_pkg::Q_IN_RANGE: qual_met = (dur > lo) && (dur < hi);
      trig_pkg::Q_OUT_RANGE: qual_met = (dur < lo) || (dur > hi);
      default: qual_met = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pattern comparison
  // ------------------------------------------------------------
  pattern_compare u_compare (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_probe(i_probe),
    .i_pattern(pattern),
    .i_func(func),
    .o_true(pat_true)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pat_prev <= 1'b0;
    end else begin
      pat_prev <= pat_true;
    end
  end

  assign rise = pat_true & ~pat_prev;
  assign fall = ~pat_true & pat_prev;

  // ------------------------------------------------------------
  // qualification decisions
  // ------------------------------------------------------------
  // limits below the smallest settable value are raised to it
  assign eff_limit = (limit < trig_pkg::MIN_LIMIT_CYC) ? trig_pkg::MIN_LIMIT_CYC : limit;
  assign eff_upper = (upper < trig_pkg::MIN_LIMIT_CYC) ? trig_pkg::MIN_LIMIT_CYC : upper;
  assign dur_now = (state == ST_TIMING) ? timer + 32'h1 : 32'h1;
  assign armed_phase = (state == ST_WAIT_FALSE) || (state == ST_ARMED) || (state == ST_TIMING);
  assign timeout_hit = (qual == trig_pkg::Q_TIMEOUT) && pat_true && (dur_now >= eff_limit) &&
                       ((state == ST_ARMED && rise) || state == ST_TIMING);
  assign gate_hit = (state == ST_TIMING) && fall && qual_met(qual, timer, eff_limit, eff_upper);
  assign qual_fire = ctrl_en & (timeout_hit | gate_hit);
  // wait scales with the timebase; a zero timebase still waits one cycle
  assign auto_wait = 32'(timebase) * 32'(P_AUTO_SCALE);
  assign force_now = ctrl_en && ctrl_auto && armed_phase && !qual_fire &&
                     (auto_cnt + 32'h1 >= auto_wait);
  assign fire = qual_fire | force_now;

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (!ctrl_en) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: next_state = ST_HOLDOFF;
        ST_HOLDOFF: begin
          if (hold_cnt == 32'h0) begin
            next_state = ST_WAIT_FALSE;
          end
        end
        ST_WAIT_FALSE: begin
          if (fire) begin
            next_state = ST_HOLDOFF;
          end else if (!pat_true) begin
            next_state = ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (fire) begin
            next_state = ST_HOLDOFF;
          end else if (rise) begin
            next_state = ST_TIMING;
          end
        end
        ST_TIMING: begin
          if (fire) begin
            next_state = ST_HOLDOFF;
          end else if (fall) begin
            next_state = ST_ARMED;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // holdoff length is percent times a fixed step
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      hold_cnt <= 32'h0;
    end else if (next_state == ST_HOLDOFF && state != ST_HOLDOFF) begin
      hold_cnt <= 32'(holdoff_pct) * 32'(P_HOLDOFF_STEP);
    end else if (state == ST_HOLDOFF && hold_cnt != 32'h0) begin
      hold_cnt <= hold_cnt - 32'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      timer <= 32'h0;
    end else if (next_state != ST_TIMING) begin
      timer <= 32'h0;
    end else if (state == ST_ARMED) begin
      timer <= 32'h1;
    end else begin
      timer <= timer + 32'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      auto_cnt <= 32'h0;
    end else if (!armed_phase || fire) begin
      auto_cnt <= 32'h0;
    end else begin
      auto_cnt <= auto_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_trig <= 1'b0;
      o_forced <= 1'b0;
      trig_count <= 32'h0;
    end else begin
      o_trig <= fire;
      o_forced <= force_now;
      if (fire) begin
        trig_count <= trig_count + 32'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl_en <= 1'b0;
      ctrl_auto <= 1'b0;
      func <= trig_pkg::FN_AND;
      qual <= trig_pkg::Q_TIMEOUT;
      limit <= trig_pkg::LIMIT_RST;
      upper <= trig_pkg::UPPER_RST;
      holdoff_pct <= trig_pkg::HOLDOFF_RST;
      timebase <= trig_pkg::TIMEBASE_RST;
    end else if (i_wr) begin
      case (i_addr)
        trig_pkg::REG_CTRL: begin
          ctrl_en <= i_wdata[trig_pkg::CTRL_EN_BIT];
          ctrl_auto <= i_wdata[trig_pkg::CTRL_AUTO_BIT];
          func <= trig_pkg::logic_func_t'(i_wdata[trig_pkg::CTRL_FUNC_LSB +: 2]);
          qual <= trig_pkg::qual_t'(i_wdata[trig_pkg::CTRL_QUAL_LSB +: 3]);
        end
        trig_pkg::REG_LIMIT: limit <= i_wdata;
        trig_pkg::REG_UPPER: upper <= i_wdata;
        trig_pkg::REG_HOLDOFF: begin
          holdoff_pct <= (i_wdata[7:0] > trig_pkg::HOLDOFF_MAX_PCT) ?
                         trig_pkg::HOLDOFF_MAX_PCT : i_wdata[7:0];
        end
        trig_pkg::REG_TIMEBASE: timebase <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // selector steps down after each level write, wrapping to the aux input
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      channel_selector <= trig_pkg::SEL_MAX;
      pattern <= '0;
    end else if (i_wr && i_addr == trig_pkg::REG_SEL) begin
      channel_selector <= (i_wdata[4:0] > trig_pkg::SEL_MAX) ? trig_pkg::SEL_MAX : i_wdata[4:0];
    end else if (i_wr && i_addr == trig_pkg::REG_LEVEL) begin
      pattern.care[channel_selector] <= (i_wdata[1:0] == trig_pkg::LVL_HIGH) ||
                                        (i_wdata[1:0] == trig_pkg::LVL_LOW);
      pattern.lvl_high[channel_selector] <= (i_wdata[1:0] == trig_pkg::LVL_HIGH);
      channel_selector <= (channel_selector == 5'h0) ? trig_pkg::SEL_MAX :
                          channel_selector - 5'h1;
    end
  end

  always_comb begin
    case (i_addr)
      trig_pkg::REG_CTRL: read_val = {21'h0, qual, 2'h0, func, 2'h0, ctrl_auto, ctrl_en};
      trig_pkg::REG_SEL: read_val = {27'h0, channel_selector};
      trig_pkg::REG_LIMIT: read_val = limit;
      trig_pkg::REG_UPPER: read_val = upper;
      trig_pkg::REG_HOLDOFF: read_val = {24'h0, holdoff_pct};
      trig_pkg::REG_TIMEBASE: read_val = {16'h0, timebase};
      trig_pkg::REG_STATUS: read_val = {27'h0, pat_true, state == ST_TIMING, state == ST_ARMED,
                                        state == ST_WAIT_FALSE, state == ST_HOLDOFF};
      trig_pkg::REG_CARE: read_val = {15'h0, pattern.care};
      trig_pkg::REG_HIGH: read_val = {15'h0, pattern.lvl_high};
      trig_pkg::REG_COUNT: read_val = trig_count;
      default: read_val = 32'h0;
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? read_val : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  property p_all_ignore;
    (pattern.care == 17'h0) |=> !pat_true;
  endproperty
  a_all_ignore: assert property (p_all_ignore) else $error("pattern true with all ignored");

  property p_sel_dec;
    (i_wr && i_addr == trig_pkg::REG_LEVEL && channel_selector != 5'h0)
      |=> channel_selector == $past(channel_selector) - 5'h1;
  endproperty
  a_sel_dec: assert property (p_sel_dec) else $error("selector did not step down");

  property p_normal_no_force;
    !ctrl_auto |=> !o_forced;
  endproperty
  a_normal_no_force: assert property (p_normal_no_force) else $error("forced in normal mode");

  sequence s_auto_due;
    ctrl_en && ctrl_auto && armed_phase && !qual_fire && (auto_cnt + 32'h1 >= auto_wait);
  endsequence
  property p_auto_force;
    s_auto_due |=> o_trig && o_forced;
  endproperty
  a_auto_force: assert property (p_auto_force) else $error("auto wait did not force");

  sequence s_timing_keep;
    state == ST_TIMING && pat_true ##1 state == ST_TIMING;
  endsequence
  property p_timer_run;
    s_timing_keep |-> timer == $past(timer) + 32'h1;
  endproperty
  a_timer_run: assert property (p_timer_run) else $error("timer did not advance");

  property p_timeout;
    (ctrl_en && state == ST_TIMING && qual == trig_pkg::Q_TIMEOUT && pat_true &&
     timer + 32'h1 >= eff_limit) |=> o_trig && !o_forced;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not fire");

  sequence s_fall_timed;
    ctrl_en && state == ST_TIMING && fall;
  endsequence
  property p_longer;
    s_fall_timed and (qual == trig_pkg::Q_LONGER && timer > eff_limit) |=> o_trig;
  endproperty
  a_longer: assert property (p_longer) else $error("longer-than missed");

  property p_shorter;
    s_fall_timed and (qual == trig_pkg::Q_SHORTER && timer < eff_limit) |=> o_trig;
  endproperty
  a_shorter: assert property (p_shorter) else $error("shorter-than missed");

  property p_in_range;
    s_fall_timed and (qual == trig_pkg::Q_IN_RANGE && (timer <= eff_limit || timer >= eff_upper))
      |=> !o_trig || o_forced;
  endproperty
  a_in_range: assert property (p_in_range) else $error("in-range fired outside window");

  property p_out_range;
    s_fall_timed and (qual == trig_pkg::Q_OUT_RANGE && (timer < eff_limit || timer > eff_upper))
      |=> o_trig;
  endproperty
  a_out_range: assert property (p_out_range) else $error("out-of-range missed");

  property p_rearm;
    (state == ST_TIMING && fall && !fire && ctrl_en) |=> state == ST_ARMED && timer == 32'h0;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no re-arm after failed pattern");

  property p_holdoff;
    o_trig |-> state == ST_HOLDOFF ##1 (state == ST_HOLDOFF || state == ST_WAIT_FALSE ||
                                         state == ST_IDLE);
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("trigger not followed by holdoff");

endmodule // pattern_trigger_time_qualifier

// ---- rtl/trig_pkg.sv ----
// shared constants, register map and types for the pattern trigger
package trig_pkg;

  // ------------------------------------------------------------
  // inputs
  // ------------------------------------------------------------
  localparam int N_IN = 17;
  localparam logic [4:0] SEL_MAX = 5'h10;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEL = 8'h04;
  localparam logic [7:0] REG_LEVEL = 8'h08;
  localparam logic [7:0] REG_LIMIT = 8'h0c;
  localparam logic [7:0] REG_UPPER = 8'h10;
  localparam logic [7:0] REG_HOLDOFF = 8'h14;
  localparam logic [7:0] REG_TIMEBASE = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_CARE = 8'h20;
  localparam logic [7:0] REG_HIGH = 8'h24;
  localparam logic [7:0] REG_COUNT = 8'h28;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_FUNC_LSB = 4;
  localparam int CTRL_QUAL_LSB = 8;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] LVL_IGNORE = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  typedef enum logic [1:0] {FN_AND = 2'h0, FN_NAND = 2'h1, FN_OR = 2'h2, FN_NOR = 2'h3} logic_func_t;

  typedef enum logic [2:0] {
    Q_SHORTER = 3'h0,
    Q_LONGER = 3'h1,
    Q_TIMEOUT = 3'h2,
    Q_IN_RANGE = 3'h3,
    Q_OUT_RANGE = 3'h4
  } qual_t;

  typedef struct packed {
    logic [16:0] care;
    logic [16:0] lvl_high;
  } pattern_t;

  // ------------------------------------------------------------
  // reset values and holdoff maximum
  // ------------------------------------------------------------
  localparam logic [31:0] LIMIT_RST = 32'h0000_0001;
  localparam logic [31:0] UPPER_RST = 32'h0000_0010;
  localparam logic [7:0] HOLDOFF_RST = 8'h0a;
  localparam logic [7:0] HOLDOFF_MAX_PCT = 8'h64;
  localparam logic [15:0] TIMEBASE_RST = 16'h0100;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MIN_LIMIT_PS = 2000;
  localparam int MIN_LIMIT_RAW = (MIN_LIMIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [31:0] MIN_LIMIT_CYC = (MIN_LIMIT_RAW < 1) ? 32'h1 : 32'(MIN_LIMIT_RAW);
  localparam int HOLDOFF_STEP_CYC = 64;
  localparam int AUTO_SCALE_CYC = 16;

endpackage

// ---- rtl/pattern_compare.sv ----
// synchronises the probed inputs and forms the combined pattern result
`timescale 1ns/1ps
module pattern_compare (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // probed inputs and setup
  input wire logic [16:0] i_probe,
  input trig_pkg::pattern_t i_pattern,
  input trig_pkg::logic_func_t i_func,
  // result
  output logic o_true
);

  logic [16:0] sync_a;
  logic [16:0] sync_b;
  logic [16:0] match;
  logic all_match;
  logic any_match;
  logic next_true;

  // ------------------------------------------------------------
  // two-stage synchroniser, one per input
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < trig_pkg::N_IN; g++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= i_probe[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // comparison
  // ------------------------------------------------------------
  assign match = ~(sync_b ^ i_pattern.lvl_high) & i_pattern.care;
  assign all_match = (match == i_pattern.care);
  assign any_match = |match;

  always_comb begin
    case (i_func)
      trig_pkg::FN_AND: next_true = all_match;
      trig_pkg::FN_NAND: next_true = ~all_match;
      trig_pkg::FN_OR: next_true = any_match;
      trig_pkg::FN_NOR: next_true = ~any_match;
      default: next_true = 1'b0;
    endcase
  end

  // all-ignore pattern never compares true
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_true <= 1'b0;
    end else begin
      o_true <= next_true & (|i_pattern.care);
    end
  end

endmodule // pattern_compare

// ---- tb/probe_source.sv ----
// probed signal source standing in for the system under test
`timescale 1ns/1ps
module probe_source (
  // clock
  input wire logic i_clk_sys,
  // requested levels
  input wire logic [16:0] i_level,
  // probed lines
  output logic [16:0] o_probe
);
  // launched from the sampling clock, so widths are exact cycle counts
  always @(posedge i_clk_sys) begin
    o_probe <= i_level;
  end
endmodule // probe_source

// ---- tb/testbench.sv ----
// self-checking bench for the pattern trigger with time qualification
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic i_clk_sys;
  logic i_srst;
  logic [16:0] probe_req;
  logic [16:0] probe;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic trig;
  logic forced;
  int err_total;
  int cmp_count;
  int trig_n;
  int forced_n;
  int f0;
  logic [1:0] ff[8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [16:0] fb[8] = '{17'h0, 17'h0, 17'h3, 17'h3, 17'h0, 17'h0, 17'h3, 17'h3};
  logic [16:0] fv[8] = '{17'h3, 17'h1, 17'h1, 17'h3, 17'h2, 17'h0, 17'h0, 17'h2};
  logic fe[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  // qualifier, duration, expected; limit 4, upper 8, bounds exclusive except the timeout limit
  logic [2:0] qq[12] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4};
  int qn[12] = '{3, 4, 5, 4, 4, 3, 5, 4, 8, 3, 9, 8};
  logic qe[12] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  probe_source probe_source_i (.i_clk_sys(i_clk_sys), .i_level(probe_req), .o_probe(probe));

  // short holdoff step and auto scale keep the run small
  pattern_trigger_time_qualifier #(.P_HOLDOFF_STEP(2), .P_AUTO_SCALE(1))
    pattern_trigger_time_qualifier_i (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_probe(probe), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_trig(trig), .o_forced(forced));

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // trigger pulses stand one cycle; counted mid-cycle, where they are settled
  always @(negedge i_clk_sys) begin
    if (trig === 1'b1) trig_n++;
    if (forced === 1'b1) forced_n++;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] f, input logic [2:0] q, input logic au);
    return 32'h1 | (32'(au) << trig_pkg::CTRL_AUTO_BIT) | (32'(f) << trig_pkg::CTRL_FUNC_LSB)
      | (32'(q) << trig_pkg::CTRL_QUAL_LSB);
  endfunction

  // base level long enough to re-arm, then v held n cycles
  task automatic pulse(input logic [16:0] base, input logic [16:0] v, input int n,
                       input logic exp, input string name);
    int t0;
    @(posedge i_clk_sys);
    probe_req <= base;
    repeat (8) @(posedge i_clk_sys);
    t0 = trig_n;
    probe_req <= v;
    repeat (n) @(posedge i_clk_sys);
    probe_req <= base;
    repeat (12) @(posedge i_clk_sys);
    chk(name, 32'(trig_n != t0), 32'(exp));
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #250000;
    err_total++;
    final_report();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    probe_req = 17'h0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    // disabled, normal mode, and, timeout qualifier code in [10:8]
    rd_chk("ctrl", trig_pkg::REG_CTRL, 32'h200);
    rd_chk("sel", trig_pkg::REG_SEL, 32'h10);
    rd_chk("limit", trig_pkg::REG_LIMIT, trig_pkg::LIMIT_RST);
    rd_chk("upper", trig_pkg::REG_UPPER, trig_pkg::UPPER_RST);
    rd_chk("holdoff", trig_pkg::REG_HOLDOFF, 32'(trig_pkg::HOLDOFF_RST));
    rd_chk("timebase", trig_pkg::REG_TIMEBASE, 32'(trig_pkg::TIMEBASE_RST));
    rd_chk("unmapped", 8'h3c, 32'h0);
    wr_reg(trig_pkg::REG_HOLDOFF, 32'hff);
    rd_chk("holdoff clamp", trig_pkg::REG_HOLDOFF, 32'h64);
    wr_reg(trig_pkg::REG_CARE, 32'h1ffff);
    rd_chk("care read only", trig_pkg::REG_CARE, 32'h0);
    wr_reg(trig_pkg::REG_LIMIT, 32'h0);
    // stored as written; the smallest limit is applied inside the qualifier
    rd_chk("limit zero", trig_pkg::REG_LIMIT, 32'h0);
    $display("test registers done");
    // empty pattern in normal mode must stay silent, auto mode then forces
    wr_reg(trig_pkg::REG_HOLDOFF, 32'h0);
    wr_reg(trig_pkg::REG_TIMEBASE, 32'h20);
    wr_reg(trig_pkg::REG_CTRL, ctl(2'h0, 3'h2, 1'b0));
    pulse(17'h0, 17'h1ffff, 6, 1'b0, "all ignore");
    repeat (80) @(posedge i_clk_sys);
    chk("normal no force", 32'(trig_n + forced_n), 32'h0);
    wr_reg(trig_pkg::REG_CTRL, ctl(2'h0, 3'h2, 1'b1));
    repeat (80) @(posedge i_clk_sys);
    chk("auto force", 32'(forced_n != 0), 32'h1);
    wr_reg(trig_pkg::REG_CTRL, 32'h0);
    $display("test modes done");
    // two elements high through the decrementing selector
    wr_reg(trig_pkg::REG_SEL, 32'h1);
    wr_reg(trig_pkg::REG_LEVEL, 32'h2);
    wr_reg(trig_pkg::REG_LEVEL, 32'h2);
    rd_chk("sel wrap", trig_pkg::REG_SEL, 32'h10);
    wr_reg(trig_pkg::REG_SEL, 32'h5);
    wr_reg(trig_pkg::REG_LEVEL, 32'h1);
    rd_chk("sel dec", trig_pkg::REG_SEL, 32'h4);
    rd_chk("care", trig_pkg::REG_CARE, 32'h23);
    rd_chk("high", trig_pkg::REG_HIGH, 32'h3);
    wr_reg(trig_pkg::REG_SEL, 32'h5);
    wr_reg(trig_pkg::REG_LEVEL, 32'h0);
    rd_chk("care ignore", trig_pkg::REG_CARE, 32'h3);
    $display("test pattern done");
    // 10 percent of holdoff covers the first pulse entirely
    wr_reg(trig_pkg::REG_HOLDOFF, 32'ha);
    wr_reg(trig_pkg::REG_CTRL, ctl(2'h0, 3'h2, 1'b0));
    pulse(17'h0, 17'h3, 6, 1'b0, "in holdoff");
    pulse(17'h0, 17'h3, 6, 1'b1, "after holdoff");
    wr_reg(trig_pkg::REG_HOLDOFF, 32'h0);
    $display("test holdoff done");
    f0 = forced_n;
    for (int i = 0; i < 8; i++) begin
      wr_reg(trig_pkg::REG_CTRL, ctl(ff[i], 3'h2, 1'b0));
      pulse(fb[i], fv[i], 6, fe[i], "function");
    end
    // limit still zero: a single true cycle must fire the timeout
    wr_reg(trig_pkg::REG_CTRL, ctl(2'h0, 3'h2, 1'b0));
    pulse(17'h0, 17'h3, 1, 1'b1, "min limit");
    $display("test functions done");
    wr_reg(trig_pkg::REG_LIMIT, 32'h4);
    wr_reg(trig_pkg::REG_UPPER, 32'h8);
    for (int i = 0; i < 12; i++) begin
      wr_reg(trig_pkg::REG_CTRL, ctl(2'h0, qq[i], 1'b0));
      pulse(17'h0, 17'h3, qn[i], qe[i], "qualifier");
    end
    chk("no force in normal", 32'(forced_n - f0), 32'h0);
    rd_chk("status armed", trig_pkg::REG_STATUS, 32'h4);
    rd_chk("count", trig_pkg::REG_COUNT, 32'(trig_n));
    $display("test qualifiers done");
    final_report();
  end
endmodule // testbench
